/* pkg/pio_line_defines.svh */
// Register offsets, reset values and widths for the I/O line controller
`ifndef PIO_LINE_DEFINES_SVH
`define PIO_LINE_DEFINES_SVH

`define NUM_LINES            32
`define ADDR_W               8
`define LINE_MASK            32'hFFFFFFFF
`define OWN_MASK             32'hFFFFFFFF
`define OWN_RESET            32'hFFFFFFFF
`define ZERO_WORD            32'h00000000
`define OFS_OWN_ENABLE       8'h00
`define OFS_OWN_DISABLE      8'h04
`define OFS_OWN_STATUS       8'h08
`define OFS_DRV_ENABLE       8'h10
`define OFS_DRV_DISABLE      8'h14
`define OFS_DRV_STATUS       8'h18
`define OFS_FLT_ENABLE       8'h20
`define OFS_FLT_DISABLE      8'h24
`define OFS_FLT_STATUS       8'h28
`define OFS_VAL_SET          8'h30
`define OFS_VAL_CLEAR        8'h34
`define OFS_VAL_STATUS       8'h38
`define OFS_PIN_STATUS       8'h3C
`define OFS_IRQ_ENABLE       8'h40
`define OFS_IRQ_DISABLE      8'h44
`define OFS_IRQ_MASK         8'h48
`define OFS_IRQ_FLAGS        8'h4C
`define OFS_DW_ENABLE        8'hA0
`define OFS_DW_DISABLE       8'hA4
`define OFS_DW_STATUS        8'hA8
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

/* pkg/pio_line_pkg.sv */
// Types shared by the I/O line controller
package pio_line_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  addr_t;
  typedef logic [1:0]  resp_t;
endpackage : pio_line_pkg

/* verilog/glitch_filter.sv */
// Per-line input glitch filter: passes a level only once stable two cycles
`timescale 1ns/1ps
`default_nettype none
`include "pio_line_defines.svh"
module glitch_filter
  import pio_line_pkg::*;
(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  ce,
  input  wire word_t raw_in,
  input  wire word_t filt_en,
  output var  word_t level_out
);
  word_t prev_ff;
  word_t hold_ff;

  // A pulse shorter than one cycle never reaches hold_ff
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff <= `ZERO_WORD;
      hold_ff <= `ZERO_WORD;
    end else if (ce) begin
      prev_ff <= raw_in;
      hold_ff <= (raw_in & ~(raw_in ^ prev_ff)) | (hold_ff & (raw_in ^ prev_ff));
    end
  end

  // Unfiltered lines bypass the hold stage
  assign level_out = (filt_en & hold_ff) | (~filt_en & raw_in);
endmodule : glitch_filter
`default_nettype wire

/* verilog/pio_line_ctrl.sv */
// AXI4-Lite controlled per-line control and status for 32 parallel I/O lines
// Function
// [R1] Disable write hands line to peripheral
// [R2] Ownership status: one controller, zero peripheral
// [R3] Driver enable write turns driver on
// [R4] Driver disable write turns driver off
// [R5] Driver status reads driver state
// [R6] Filter enable write turns filter on
// [R7] Filter disable write turns filter off
// [R8] Filter status reads filter state
// [R9] Set write makes drive value one
// [R10] Clear write makes drive value zero
// [R11] Drive value status reads scheduled value
// [R12] Drive value status partly writable
// [R13] Pin level status reads sampled pins
// [R14] Irq enable write arms change interrupt
// [R15] Irq disable write disarms change interrupt
// [R16] Registers 32 bits, bit n line n
// [R17] Unimplemented lines ignore writes, read zero
// [R18] Direct-write permit bit gates status writes
// [R19] Change flags latch, clear on read
// [R20] Each pair updates one stored bit
// [R21] Owned, enabled line drives stored value
`timescale 1ns/1ps
`default_nettype none
`include "pio_line_defines.svh"
module pio_line_ctrl
  import pio_line_pkg::*;
(
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  ce,
  input  wire addr_t s_axi_awaddr,
  input  wire logic  s_axi_awvalid,
  output var  logic  s_axi_awready,
  input  wire word_t s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic  s_axi_wvalid,
  output var  logic  s_axi_wready,
  output var  resp_t s_axi_bresp,
  output var  logic  s_axi_bvalid,
  input  wire logic  s_axi_bready,
  input  wire addr_t s_axi_araddr,
  input  wire logic  s_axi_arvalid,
  output var  logic  s_axi_arready,
  output var  word_t s_axi_rdata,
  output var  resp_t s_axi_rresp,
  output var  logic  s_axi_rvalid,
  input  wire logic  s_axi_rready,
  input  wire word_t pin_in,
  output var  word_t pin_out,
  output var  word_t pin_oe,
  output var  word_t periph_sel,
  output var  word_t change_irq_pending
);
  // ****************************************
  // Write channel capture
  // ****************************************
  addr_t waddr_ff;
  word_t wdata_ff;
  logic  aw_got_ff;
  logic  w_got_ff;
  logic  wr_go;
  logic  b_done;

  function automatic word_t strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  function automatic logic known_addr(input addr_t a, input logic rd);
    case (a)
      `OFS_OWN_STATUS, `OFS_DRV_STATUS, `OFS_FLT_STATUS, `OFS_PIN_STATUS,
      `OFS_IRQ_MASK, `OFS_IRQ_FLAGS, `OFS_DW_STATUS:
        known_addr = rd;
      `OFS_OWN_ENABLE, `OFS_OWN_DISABLE, `OFS_DRV_ENABLE, `OFS_DRV_DISABLE,
      `OFS_FLT_ENABLE, `OFS_FLT_DISABLE, `OFS_VAL_SET, `OFS_VAL_CLEAR,
      `OFS_IRQ_ENABLE, `OFS_IRQ_DISABLE, `OFS_DW_ENABLE, `OFS_DW_DISABLE:
        known_addr = !rd;
      `OFS_VAL_STATUS:
        known_addr = 1'b1;
      default:
        known_addr = 1'b0;
    endcase
  endfunction : known_addr

  assign wr_go  = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign b_done = s_axi_bvalid && s_axi_bready;

  // Address and data accepted in either order, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      waddr_ff      <= 8'h00;
      wdata_ff      <= `ZERO_WORD;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !aw_got_ff && !s_axi_awready && !wr_go && !s_axi_bvalid;
      s_axi_wready  <= !w_got_ff && !s_axi_wready && !wr_go && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        waddr_ff  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata & strb_mask(s_axi_wstrb);
      end
      if (wr_go) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_addr(waddr_ff, 1'b0) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  // Only lines that exist may be touched; the rest is masked away
  word_t wbits;
  assign wbits = wdata_ff & `LINE_MASK;                         // [R17]

  function automatic word_t hit(input logic go, input addr_t a, input addr_t o,
                                input word_t d);
    hit = (go && a == o) ? d : `ZERO_WORD;
  endfunction : hit

  word_t own_en_w, own_dis_w, drv_en_w, drv_dis_w, flt_en_w, flt_dis_w;
  word_t val_set_w, val_clr_w, val_dir_w, irq_en_w, irq_dis_w, dw_en_w, dw_dis_w;
  logic  val_dir_hit;
  assign own_en_w    = hit(wr_go, waddr_ff, `OFS_OWN_ENABLE, wbits);
  assign own_dis_w   = hit(wr_go, waddr_ff, `OFS_OWN_DISABLE, wbits);
  assign drv_en_w    = hit(wr_go, waddr_ff, `OFS_DRV_ENABLE, wbits);
  assign drv_dis_w   = hit(wr_go, waddr_ff, `OFS_DRV_DISABLE, wbits);
  assign flt_en_w    = hit(wr_go, waddr_ff, `OFS_FLT_ENABLE, wbits);
  assign flt_dis_w   = hit(wr_go, waddr_ff, `OFS_FLT_DISABLE, wbits);
  assign val_set_w   = hit(wr_go, waddr_ff, `OFS_VAL_SET, wbits);
  assign val_clr_w   = hit(wr_go, waddr_ff, `OFS_VAL_CLEAR, wbits);
  assign irq_en_w    = hit(wr_go, waddr_ff, `OFS_IRQ_ENABLE, wbits);
  assign irq_dis_w   = hit(wr_go, waddr_ff, `OFS_IRQ_DISABLE, wbits);
  assign dw_en_w     = hit(wr_go, waddr_ff, `OFS_DW_ENABLE, wbits);
  assign dw_dis_w    = hit(wr_go, waddr_ff, `OFS_DW_DISABLE, wbits);
  assign val_dir_hit = wr_go && waddr_ff == `OFS_VAL_STATUS;

  // ****************************************
  // Per-line stored state
  // ****************************************
  word_t own_ff, drv_ff, flt_ff, val_ff, irq_ff, dw_ff, flags_ff;
  word_t nxt_own, nxt_drv, nxt_flt, nxt_val, nxt_irq, nxt_dw, nxt_flags;
  word_t dw_mask;

  function automatic word_t pair(input word_t cur, input word_t en, input word_t dis);
    pair = (cur | en) & ~dis;
  endfunction : pair

  // Enable and disable of a pair both act on one stored bit
  assign nxt_own = pair(own_ff, own_en_w, own_dis_w) & `OWN_MASK; // [R1] [R20]
  assign nxt_drv = pair(drv_ff, drv_en_w, drv_dis_w);           // [R3] [R4] [R20]
  assign nxt_flt = pair(flt_ff, flt_en_w, flt_dis_w);           // [R6] [R7] [R20]
  assign nxt_irq = pair(irq_ff, irq_en_w, irq_dis_w);           // [R14] [R15] [R20]
  assign nxt_dw  = pair(dw_ff, dw_en_w, dw_dis_w);

  // Direct writes reach only lines whose permit bit is set
  assign dw_mask = val_dir_hit ? dw_ff : `ZERO_WORD;            // [R12] [R18]
  assign nxt_val = ((val_ff | val_set_w) & ~val_clr_w & ~dw_mask)
                   | (wbits & dw_mask);                         // [R9] [R10] [R12]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      own_ff <= `OWN_RESET;
      drv_ff <= `ZERO_WORD;
      flt_ff <= `ZERO_WORD;
      val_ff <= `ZERO_WORD;
      irq_ff <= `ZERO_WORD;
      dw_ff  <= `ZERO_WORD;
    end else if (ce) begin
      own_ff <= nxt_own;
      drv_ff <= nxt_drv;
      flt_ff <= nxt_flt;
      val_ff <= nxt_val;
      irq_ff <= nxt_irq;
      dw_ff  <= nxt_dw;
    end
  end

  // ****************************************
  // Pin sampling and change detection
  // ****************************************
  // Two-stage synchroniser; stage one feeds stage two only
  word_t pin_s1_ff, pin_s2_ff, level_w, level_ff;
  logic  level_vld_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff <= `ZERO_WORD;
      pin_s2_ff <= `ZERO_WORD;
    end else if (ce) begin
      pin_s1_ff <= pin_in;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  glitch_filter u_filter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .raw_in    (pin_s2_ff),
    .filt_en   (flt_ff),
    .level_out (level_w)
  );

  // Change flags; set wins over read-clear so no edge is lost
  word_t change_w, rd_clr_w;
  logic  flags_read;
  assign change_w  = level_vld_ff ? (level_w ^ level_ff) & irq_ff : `ZERO_WORD;
  assign nxt_flags = (flags_ff & ~rd_clr_w) | change_w;        // [R19]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_ff           <= `ZERO_WORD;
      level_vld_ff       <= 1'b0;
      flags_ff           <= `ZERO_WORD;
      change_irq_pending <= `ZERO_WORD;
    end else if (ce) begin
      level_ff           <= level_w;
      level_vld_ff       <= 1'b1;  // Skip the first compare after reset
      flags_ff           <= nxt_flags;
      change_irq_pending <= nxt_flags;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  // Only an owned line with its driver on is driven from the stored value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out    <= `ZERO_WORD;
      pin_oe     <= `ZERO_WORD;
      periph_sel <= `ZERO_WORD;
    end else if (ce) begin
      pin_out    <= nxt_val;                                    // [R21]
      pin_oe     <= nxt_own & nxt_drv;                          // [R21]
      periph_sel <= ~nxt_own & `LINE_MASK;                      // [R1]
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  word_t rmux;
  addr_t raddr;
  assign raddr = {s_axi_araddr[7:2], 2'b00};
  assign rmux =
    (raddr == `OFS_OWN_STATUS) ? own_ff :                       // [R2]
    (raddr == `OFS_DRV_STATUS) ? drv_ff :                       // [R5]
    (raddr == `OFS_FLT_STATUS) ? flt_ff :                       // [R8]
    (raddr == `OFS_VAL_STATUS) ? val_ff :                       // [R11]
    (raddr == `OFS_PIN_STATUS) ? level_w :                      // [R13]
    (raddr == `OFS_IRQ_MASK)   ? irq_ff :
    (raddr == `OFS_IRQ_FLAGS)  ? flags_ff :
    (raddr == `OFS_DW_STATUS)  ? dw_ff : `ZERO_WORD;
  logic rd_take;
  assign rd_take    = s_axi_arvalid && s_axi_arready;
  assign flags_read = rd_take && raddr == `OFS_IRQ_FLAGS;
  assign rd_clr_w   = flags_read ? flags_ff : `ZERO_WORD;     // [R19]

  // Whole 32-bit words, unused lines read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `ZERO_WORD;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rmux & `LINE_MASK;                      // [R16] [R17]
        s_axi_rresp  <= known_addr(raddr, 1'b1) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : pio_line_ctrl
`default_nettype wire

/* dv/pin_partner.sv */
// Pad model: resolves each line from the driver and the outside world
`timescale 1ns/1ps
`default_nettype none
module pin_partner
  import pio_line_pkg::*;
(
  input  wire word_t pin_out,
  input  wire word_t pin_oe,
  input  wire word_t ext_level,
  output var  word_t pin_in
);
  // ****************
  // Pad resolution
  // ****************
  // Enabled driver wins; the bench also sets ext_level on driven lines, and no contention is modelled
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : pin_partner
`default_nettype wire

/* dv/pio_line_monitor.sv */
// Concurrent checks on the I/O line controller ports
`timescale 1ns/1ps
`default_nettype none
module pio_line_monitor
  import pio_line_pkg::*;
(
  input wire logic  aclk,
  input wire logic  aresetn,
  input wire logic  ce,
  input wire logic  s_axi_awvalid,
  input wire logic  s_axi_awready,
  input wire logic  s_axi_wvalid,
  input wire logic  s_axi_wready,
  input wire logic  s_axi_bvalid,
  input wire logic  s_axi_bready,
  input wire resp_t s_axi_bresp,
  input wire addr_t s_axi_araddr,
  input wire logic  s_axi_arvalid,
  input wire logic  s_axi_arready,
  input wire logic  s_axi_rvalid,
  input wire logic  s_axi_rready,
  input wire word_t s_axi_rdata,
  input wire resp_t s_axi_rresp,
  input wire word_t pin_out,
  input wire word_t pin_oe,
  input wire word_t periph_sel
);
  // ****************
  // Bus and pins
  // ****************
  // Frozen state under a low enable would trip the timing checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data not on time");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_hole_read: assert property (rd_taken and s_axi_araddr == 8'h0C |=> s_axi_rdata == 32'h0 && s_axi_rresp == 2'h2)
    else $error("reserved read not refused");
  a_drive_owned: assert property ((pin_oe & periph_sel) == 32'h0)
    else $error("driver on a peripheral line");
  a_drive_commit: assert property ($changed(pin_oe) || $changed(pin_out) |-> ##[0:2] s_axi_bvalid)
    else $error("pins moved without a write");
  a_ready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("address ready held");
endmodule : pio_line_monitor
bind pio_line_ctrl pio_line_monitor u_mon (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .pin_out, .pin_oe, .periph_sel);
`default_nettype wire

/* dv/pio_line_ctrl_tb.sv */
// Self-checking bench for the I/O line controller
`timescale 1ns/1ps
`default_nettype none
`include "pio_line_defines.svh"
module pio_line_ctrl_tb
  import pio_line_pkg::*;
;
  // ****************
  // Stimulus and checks
  // ****************
  logic       aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic       s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic       s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_wstrb = 4'hF;
  addr_t      s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  word_t      s_axi_wdata = 32'h0, ext_level = 32'h0;
  word_t      s_axi_rdata, pin_in, pin_out, pin_oe, periph_sel, change_irq_pending;
  resp_t      s_axi_bresp, s_axi_rresp;
  int         fails = 0, check_count = 0;

  always #2 aclk = ~aclk;

  pio_line_ctrl dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .periph_sel,
    .change_irq_pending);
  pin_partner u_pins (.pin_out, .pin_oe, .ext_level, .pin_in);

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input word_t e, input word_t g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Bus cycles; the bound guards against a slave that never answers
  task automatic wr(input addr_t a, input word_t d, input resp_t er = `RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'h0;
    if (n >= 40) begin
      fails++;
      wrap_up();
    end
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input string nm, input addr_t a, input word_t e, input resp_t er = `RESP_OKAY);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 40);
    s_axi_rready <= 1'h0;
    if (n >= 40) begin
      fails++;
      wrap_up();
    end
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    chk(nm, e, s_axi_rdata);
  endtask : rd

  task automatic t_reset;
    rd("own", `OFS_OWN_STATUS, 32'hFFFFFFFF);
    rd("drv", `OFS_DRV_STATUS, 32'h0);
    rd("flt", `OFS_FLT_STATUS, 32'h0);
    rd("val", `OFS_VAL_STATUS, 32'h0);
  endtask : t_reset

  task automatic t_own;
    wr(`OFS_OWN_DISABLE, 32'h0F0F0000);
    wr(`OFS_OWN_DISABLE, 32'h0);
    rd("own", `OFS_OWN_STATUS, 32'hF0F0FFFF);
    chk("sel", 32'h0F0F0000, periph_sel);
  endtask : t_own

  // Driver bits on peripheral lines are stored but must not reach the pad
  task automatic t_drv;
    wr(`OFS_DRV_ENABLE, 32'h0F0F00FF);
    wr(`OFS_DRV_DISABLE, 32'h0000000F);
    rd("drv", `OFS_DRV_STATUS, 32'h0F0F00F0);
    chk("oe", 32'h000000F0, pin_oe);
    wr(`OFS_FLT_ENABLE, 32'h00000F00);
    wr(`OFS_FLT_DISABLE, 32'h00000300);
    rd("flt", `OFS_FLT_STATUS, 32'h00000C00);
  endtask : t_drv

  task automatic t_val;
    wr(`OFS_VAL_SET, 32'h0000F0F0);
    wr(`OFS_VAL_CLEAR, 32'h000000F0);
    rd("val", `OFS_VAL_STATUS, 32'h0000F000);
    wr(`OFS_DW_ENABLE, 32'h0000000F);
    wr(`OFS_VAL_STATUS, 32'h0000000A);
    rd("val", `OFS_VAL_STATUS, 32'h0000F00A);
    chk("out", 32'h0000F00A, pin_out);
  endtask : t_val

  task automatic t_pin_irq;
    wr(`OFS_IRQ_ENABLE, 32'h00000003);
    wr(`OFS_IRQ_DISABLE, 32'h00000002);
    @(posedge aclk);
    ext_level <= 32'h5A5A5A5A;
    repeat (8) @(posedge aclk);
    rd("pin", `OFS_PIN_STATUS, 32'h5A5A5A0A);
    rd("flg", `OFS_IRQ_FLAGS, 32'h0);
    ext_level <= 32'h5A5A5A59;
    repeat (8) @(posedge aclk);
    chk("pend", 32'h1, change_irq_pending);
    rd("flg", `OFS_IRQ_FLAGS, 32'h1);
    rd("flg", `OFS_IRQ_FLAGS, 32'h0);
  endtask : t_pin_irq

  // Late ready on both answers: response and data must stand until taken
  task automatic t_stall;
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= `OFS_DRV_STATUS;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 40);
    if (n >= 40) fails++;
    repeat (3) @(posedge aclk);
    chk("rvld", 32'h1, {31'h0, s_axi_rvalid});
    chk("drv", 32'h0F0F00F0, s_axi_rdata);
    s_axi_rready <= 1'h1;
    @(posedge aclk);
    s_axi_rready <= 1'h0;
    n = 0;
    s_axi_awaddr <= `OFS_VAL_SET;
    s_axi_wdata <= 32'h0;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 40);
    if (n >= 40) fails++;
    repeat (3) @(posedge aclk);
    chk("bvld", 32'h1, {31'h0, s_axi_bvalid});
    chk("bresp", {30'h0, `RESP_OKAY}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'h1;
    @(posedge aclk);
    s_axi_bready <= 1'h0;
    rd("val", `OFS_VAL_STATUS, 32'h0000F00A);
  endtask : t_stall

  task automatic t_hole;
    rd("hole", 8'h0C, 32'h0, `RESP_SLVERR);
    wr(`OFS_OWN_STATUS, 32'hFFFFFFFF, `RESP_SLVERR);
    rd("own", `OFS_OWN_STATUS, 32'hF0F0FFFF);
  endtask : t_hole

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_own();
    t_drv();
    t_val();
    t_pin_irq();
    t_hole();
    t_stall();
    wrap_up();
  end
endmodule : pio_line_ctrl_tb
`default_nettype wire
